// File: design/fp_slice_regs.svh
// constants for the reciprocal-estimate / round-to-single slice
// assumes: included by bare name wherever a constant is needed
`ifndef FP_SLICE_REGS_SVH
`define FP_SLICE_REGS_SVH
// instruction word fields (bit 0 of the word is the least significant)
`define OPC_RECIP 6'h3b
`define XO_RECIP 5'h18
`define OPC_ROUND 6'h3f
`define XO_ROUND 10'h00c
// register byte offsets on the bus
`define REG_STATUS_CTRL 5'h00
`define REG_COND_ONE 5'h04
`define REG_IRQ_STATUS 5'h08
`define REG_IRQ_MASK 5'h0c
`define REG_DEP_TRACK 5'h10
// fp_status_control bit positions (lsb numbering)
`define SC_FX 31
`define SC_FEX 30
`define SC_VX 29
`define SC_OX 28
`define SC_UX 27
`define SC_ZX 26
`define SC_XX 25
`define SC_SNAN_INVALID_EXCEPTION 24
`define SC_VXALL_HI 23
`define SC_VXALL_LO 19
`define SC_FR 18
`define SC_FI 17
`define SC_RESULT_FLAGS_FIELD_HI 16
`define SC_RESULT_FLAGS_FIELD_LO 12
`define SC_VXSOFT 10
`define SC_VXSQRT 9
`define SC_VXCVI 8
`define SC_VE 7
`define SC_OE 6
`define SC_UE 5
`define SC_ZE 4
`define SC_XE 3
`define SC_RN_HI 1
`define SC_RN_LO 0
`define SC_RESET 32'h0000_0000
// result class codes for result_flags_field
`define CLS_QNAN 5'h11
`define CLS_NINF 5'h09
`define CLS_NNORM 5'h08
`define CLS_NDEN 5'h18
`define CLS_NZERO 5'h12
`define CLS_PZERO 5'h02
`define CLS_PDEN 5'h14
`define CLS_PNORM 5'h04
`define CLS_PINF 5'h05
// rounding modes
`define RN_NEAREST 2'h0
`define RN_ZERO 2'h1
`define RN_PINF 2'h2
`define RN_NINF 2'h3
// number format constants
`define SP_BIAS 13'h007f
`define DP_BIAS 13'h03ff
`define DP_EXP_MAX 11'h7ff
`define DP_FROM_SP 11'h0380
`define DP_DEN_BASE 11'h036a
`define SP_MAX_DP 64'h47ef_ffff_e000_0000
`define DEFECT_POS 64'h47f0_0000_0000_0000
`define DEFECT_NEG 64'hc7f0_0000_0000_0000
`define RECIP_NUM 49'h1_0000_0000_0000
`define RECIP_DEN_EXP 13'h00c8
`define DP_DEN_EXP 13'h1c02
`endif

// File: design/fp_slice_pkg.sv
// types shared by the reciprocal-estimate / round-to-single slice
// assumes: nothing beyond the constants header
package fp_slice_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RECIP = 2'b01,
    OP_ROUND = 2'b10
  } op_kind_e;
  typedef struct packed {
    logic [63:0] value;
    logic inexact;
    logic rounded_up;
    logic ovf;
    logic unf;
    logic denorm;
    logic edge_2_128;
  } round_res_s;
  typedef struct packed {
    logic valid;
    logic [4:0] target;
    logic [63:0] data;
  } wb_s;
endpackage

// File: design/sp_rounder.sv
// rounds a sign/exponent/53-bit significand to single precision
// assumes: purely combinational, result given in double format
`timescale 1ns/100ps
`include "fp_slice_regs.svh"
module sp_rounder (
  input wire logic sgn, // sign of operand
  input wire logic signed [12:0] uexp, // unbiased exponent
  input wire logic [52:0] man, // significand, bit 52 weight 1
  input wire logic [1:0] rn, // rounding mode
  output fp_slice_pkg::round_res_s res // rounded result and flags
);
  import fp_slice_pkg::*;
  logic signed [12:0] biased;
  logic [12:0] sh_full;
  logic [6:0] sh;
  logic [79:0] wide;
  logic [23:0] keep;
  logic rbit;
  logic sticky;
  logic inc;
  logic [24:0] sum;
  logic [12:0] eb;
  logic [22:0] frac;
  logic [4:0] lead;
  logic [52:0] nrm;

  always_comb
  begin
    biased = uexp + `SP_BIAS;
    sh_full = 13'h0001 - biased;
    if (biased >= 13'sh0001)
      sh = 7'h00;
    else if (sh_full > 13'h003f)
      sh = 7'h3f;
    else
      sh = sh_full[6:0];
    wide = {man, 27'h000_0000} >> sh;
    keep = wide[79:56];
    rbit = wide[55];
    sticky = |wide[54:0];
    case (rn)
      `RN_NEAREST: inc = rbit & (sticky | keep[0]);
      `RN_ZERO: inc = 1'b0;
      `RN_PINF: inc = ~sgn & (rbit | sticky);
      `RN_NINF: inc = sgn & (rbit | sticky);
      default: inc = 1'b0;
    endcase
    sum = {1'b0, keep} + {24'h00_0000, inc};
    if (biased >= 13'sh0001)
    begin
      eb = sum[24] ? biased + 13'h0001 : biased;
      frac = sum[24] ? sum[23:1] : sum[22:0];
    end
    else
    begin
      // tiny: the shift already aligned to the denormal grid
      eb = {12'h000, sum[23]};
      frac = sum[22:0];
    end
    res.inexact = rbit | sticky;
    res.rounded_up = inc;
    res.ovf = ($signed(eb) >= $signed(13'h00ff));
    res.unf = (biased < 13'sh0001) & (rbit | sticky);
    res.denorm = (eb == 13'h0000) & (frac != 23'h00_0000);
    // below 2**128 before rounding, exactly 2**128 after
    res.edge_2_128 = (biased == 13'h00fe) & sum[24];
    lead = 5'h00;
    for (int i = 0; i < 23; i++)
      if (frac[i])
        lead = 5'(i);
    nrm = {30'h0000_0000, frac} << (6'h34 - {1'b0, lead});
    if (res.ovf)
    begin
      // overflow: infinity or largest finite according to direction
      if ((rn == `RN_ZERO) || (rn == `RN_PINF && sgn) || (rn == `RN_NINF && !sgn))
        res.value = {sgn, 63'(`SP_MAX_DP)};
      else
        res.value = {sgn, `DP_EXP_MAX, 52'h0_0000_0000_0000};
    end
    else if (eb == 13'h0000 && frac == 23'h00_0000)
      res.value = {sgn, 63'h0000_0000_0000_0000};
    else if (eb == 13'h0000)
      res.value = {sgn, `DP_DEN_BASE + {6'h00, lead}, nrm[51:0]};
    else
      res.value = {sgn, `DP_FROM_SP + eb[10:0], frac, 29'h0000_0000};
  end
endmodule // sp_rounder

// File: design/fp_recip_round_unit.sv
// reciprocal-estimate and round-to-single execution slice, one cycle
// assumes: issue logic hands the instruction and its source operand together
//
// Notes on behaviour
// - decode reciprocal estimate, opcode 59, extended 24
// - reciprocal of double source, single result written
// - estimate within one part in 256
// - infinities give signed zero, quiet nan passes
// - zero gives signed infinity, zero-divide, enable suppresses
// - signaling nan gives quiet nan, invalid suppresses
// - reciprocal sets result class unless suppressed
// - reciprocal always updates the status register
// - record flag updates cond_field_one after reciprocal
// - decode round-to-single, opcode 63, extended 12
// - round to single using rounding_control_field
// - round sets result class unless invalid suppresses
// - round always updates the status register
// - record flag updates cond_field_one after round
// - dependent round hitting 2**128 writes defect value
// - defect leaves flags as without overflow
`timescale 1ns/100ps
`include "fp_slice_regs.svh"
module fp_recip_round_unit #(
  parameter int HIST_DEPTH = 2 // fp ops that a dependent round can see back
) (
  input wire logic sys_clk, // core clock
  input wire logic rst, // asynchronous reset
  input wire logic issue_valid, // an fp instruction is offered
  input wire logic [31:0] issue_instr, // instruction word
  input wire logic [63:0] issue_src_data, // contents of source_fp_reg
  output logic issue_claim, // offered word is one of ours
  output logic [4:0] source_fp_reg, // register index to read
  input wire logic fp_op_valid, // another fp op issued this cycle
  input wire logic [4:0] fp_op_target, // its target register
  input wire logic fp_op_arith, // that op is arithmetic
  output fp_slice_pkg::wb_s wb, // register file write port
  output logic [31:0] fp_status_control, // status and control register
  output logic [3:0] cond_field_one, // condition field one
  output logic cond_field_one_we, // field one written this cycle
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic irq // level interrupt
);
  import fp_slice_pkg::*;
  localparam int HW = HIST_DEPTH;

  op_kind_e op;
  logic [4:0] target_fp_reg;
  logic record_flag;
  logic s_sgn;
  logic [10:0] s_exp;
  logic [51:0] s_frac;
  logic s_nan, s_snan, s_inf, s_zero, s_den;
  logic m_one;
  logic [23:0] m24;
  logic [48:0] qfull;
  logic [24:0] q;
  logic signed [12:0] r_uexp;
  logic [52:0] r_man;
  round_res_s rr;
  logic dep_hit;
  logic defect;
  logic [63:0] res_val;
  logic special;
  logic ex_zx, ex_snan_invalid_exception, ex_ox, ex_ux, ex_xx;
  logic suppress;
  logic [4:0] res_cls;
  logic [31:0] sc_q, sc_d, sc_base;
  logic [3:0] cr1_d;
  logic [4:0] hist_tgt_q [HW];
  logic hist_arith_q [HW];
  logic [3:0] irq_stat_q, irq_mask_q, irq_ev;
  logic bus_ack_q;
  logic bus_req;
  logic bus_wr_go;
  logic [31:0] wmask;

  // decode
  always_comb
  begin
    target_fp_reg = issue_instr[25:21];
    source_fp_reg = issue_instr[15:11];
    record_flag = issue_instr[0];
    if (issue_valid && issue_instr[31:26] == `OPC_RECIP && issue_instr[5:1] == `XO_RECIP)
      op = OP_RECIP;
    else if (issue_valid && issue_instr[31:26] == `OPC_ROUND && issue_instr[10:1] == `XO_ROUND)
      op = OP_ROUND;
    else
      op = OP_NONE;
  end
  assign issue_claim = (op != OP_NONE);

  // operand classification
  always_comb
  begin
    s_sgn = issue_src_data[63];
    s_exp = issue_src_data[62:52];
    s_frac = issue_src_data[51:0];
    s_nan = (s_exp == `DP_EXP_MAX) && (s_frac != 52'h0_0000_0000_0000);
    s_snan = s_nan && !s_frac[51];
    s_inf = (s_exp == `DP_EXP_MAX) && (s_frac == 52'h0_0000_0000_0000);
    s_zero = (s_exp == 11'h000) && (s_frac == 52'h0_0000_0000_0000);
    s_den = (s_exp == 11'h000) && !s_zero;
  end

  // reciprocal significand from the top 24 significand bits: error stays
  // near 2**-23, far inside the 1/256 bound, with no lookup table
  always_comb
  begin
    m24 = {1'b1, s_frac[51:29]};
    m_one = (s_frac[51:29] == 23'h00_0000);
    qfull = `RECIP_NUM / {25'h000_0000, m24};
    q = qfull[24:0];
    if (op == OP_RECIP)
    begin
      if (s_den)
      begin
        // reciprocal of a denormal is far beyond single range
        r_uexp = `RECIP_DEN_EXP;
        r_man = {1'b1, 52'h0_0000_0000_0000};
      end
      else if (m_one)
      begin
        r_uexp = `DP_BIAS - {2'h0, s_exp};
        r_man = {1'b1, 52'h0_0000_0000_0000};
      end
      else
      begin
        r_uexp = `DP_BIAS - 13'h0001 - {2'h0, s_exp};
        r_man = {q, 28'h000_0000};
      end
    end
    else
    begin
      r_uexp = s_den ? `DP_DEN_EXP : {2'h0, s_exp} - `DP_BIAS;
      r_man = {!s_den, s_frac};
    end
  end

  sp_rounder i_sp_rounder (
    .sgn(s_sgn),
    .uexp(r_uexp),
    .man(r_man),
    .rn(sc_q[`SC_RN_HI:`SC_RN_LO]),
    .res(rr)
  );

  // dependency on a recent arithmetic op, for the documented defect
  always_comb
  begin
    dep_hit = 1'b0;
    for (int i = 0; i < HW; i++)
      if (hist_arith_q[i] && hist_tgt_q[i] == source_fp_reg)
        dep_hit = 1'b1;
  end

  generate
    for (genvar g = 0; g < HW; g++)
    begin : g_hist
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          hist_tgt_q[g] <= 5'h00;
          hist_arith_q[g] <= 1'b0;
        end
        else if (issue_claim || fp_op_valid)
        begin
          if (g == 0)
          begin
            hist_tgt_q[g] <= issue_claim ? target_fp_reg : fp_op_target;
            hist_arith_q[g] <= !issue_claim && fp_op_arith;
          end
          else
          begin
            hist_tgt_q[g] <= hist_tgt_q[(g > 0) ? g - 1 : 0];
            hist_arith_q[g] <= hist_arith_q[(g > 0) ? g - 1 : 0];
          end
        end
      end
    end
  endgenerate

  // result and exceptions
  always_comb
  begin
    special = s_nan || s_inf || s_zero;
    ex_zx = 1'b0;
    ex_snan_invalid_exception = 1'b0;
    defect = 1'b0;
    if (s_nan)
    begin
      ex_snan_invalid_exception = s_snan;
      res_val = {s_sgn, `DP_EXP_MAX, 1'b1, s_frac[50:29], 29'h0000_0000};
    end
    else if (s_inf)
      res_val = (op == OP_RECIP) ? {s_sgn, 63'h0000_0000_0000_0000} : issue_src_data;
    else if (s_zero)
    begin
      ex_zx = (op == OP_RECIP);
      res_val = (op == OP_RECIP) ? {s_sgn, `DP_EXP_MAX, 52'h0_0000_0000_0000} : issue_src_data;
    end
    else if (op == OP_ROUND && dep_hit && rr.edge_2_128)
    begin
      defect = 1'b1;
      res_val = s_sgn ? `DEFECT_NEG : `DEFECT_POS;
    end
    else
      res_val = rr.value;
    ex_ox = !special && rr.ovf && !defect;
    ex_ux = !special && rr.unf;
    ex_xx = !special && (op == OP_ROUND) && (rr.inexact || rr.ovf);
    suppress = (ex_zx && sc_q[`SC_ZE]) || (ex_snan_invalid_exception && sc_q[`SC_VE]);
    if (s_nan)
      res_cls = `CLS_QNAN;
    else if (res_val[62:52] == `DP_EXP_MAX)
      res_cls = res_val[63] ? `CLS_NINF : `CLS_PINF;
    else if (res_val[62:0] == 63'h0000_0000_0000_0000)
      res_cls = res_val[63] ? `CLS_NZERO : `CLS_PZERO;
    else if (rr.denorm)
      res_cls = res_val[63] ? `CLS_NDEN : `CLS_PDEN;
    else
      res_cls = res_val[63] ? `CLS_NNORM : `CLS_PNORM;
  end

  // status register next value; an instruction beats a same-cycle bus write
  always_comb
  begin
    sc_base = sc_q;
    if (bus_wr_go && avs_address == `REG_STATUS_CTRL)
      sc_base = (sc_q & ~wmask) | (avs_writedata & wmask);
    sc_d = sc_base;
    if (op != OP_NONE)
    begin
      sc_d[`SC_ZX] = sc_q[`SC_ZX] | ex_zx;
      sc_d[`SC_SNAN_INVALID_EXCEPTION] = sc_q[`SC_SNAN_INVALID_EXCEPTION] | ex_snan_invalid_exception;
      sc_d[`SC_OX] = sc_q[`SC_OX] | ex_ox;
      sc_d[`SC_UX] = sc_q[`SC_UX] | ex_ux;
      sc_d[`SC_XX] = sc_q[`SC_XX] | ex_xx;
      sc_d[`SC_FR] = !special && !suppress && rr.rounded_up;
      sc_d[`SC_FI] = !special && !suppress && (rr.inexact || (rr.ovf && !defect));
      if ((ex_zx && !sc_q[`SC_ZX]) || (ex_snan_invalid_exception && !sc_q[`SC_SNAN_INVALID_EXCEPTION]) ||
          (ex_ox && !sc_q[`SC_OX]) || (ex_ux && !sc_q[`SC_UX]) ||
          (ex_xx && !sc_q[`SC_XX]))
        sc_d[`SC_FX] = 1'b1;
      if (!suppress)
        sc_d[`SC_RESULT_FLAGS_FIELD_HI:`SC_RESULT_FLAGS_FIELD_LO] = res_cls;
    end
    // summaries always follow their sources
    sc_d[`SC_VX] = sc_d[`SC_SNAN_INVALID_EXCEPTION] | (|sc_d[`SC_VXALL_HI:`SC_VXALL_LO]) |
                   sc_d[`SC_VXSOFT] | sc_d[`SC_VXSQRT] | sc_d[`SC_VXCVI];
    sc_d[`SC_FEX] = (sc_d[`SC_VX] & sc_d[`SC_VE]) | (sc_d[`SC_OX] & sc_d[`SC_OE]) |
                    (sc_d[`SC_UX] & sc_d[`SC_UE]) | (sc_d[`SC_ZX] & sc_d[`SC_ZE]) |
                    (sc_d[`SC_XX] & sc_d[`SC_XE]);
    // field one is taken from the finished status value
    cr1_d = {sc_d[`SC_FX], sc_d[`SC_FEX], sc_d[`SC_VX], sc_d[`SC_OX]};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sc_q <= `SC_RESET;
    else
      sc_q <= sc_d;
  end
  assign fp_status_control = sc_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cond_field_one <= 4'h0;
      cond_field_one_we <= 1'b0;
    end
    else
    begin
      cond_field_one_we <= (op != OP_NONE) && record_flag;
      if (op != OP_NONE && record_flag)
        cond_field_one <= cr1_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb.valid <= 1'b0;
      wb.target <= 5'h00;
      wb.data <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      wb.valid <= (op != OP_NONE) && !suppress;
      if (op != OP_NONE && !suppress)
      begin
        wb.target <= target_fp_reg;
        wb.data <= res_val;
      end
    end
  end

  // interrupt events: zero divide, snan invalid, overflow, defect written
  assign irq_ev = {defect, ex_ox, ex_snan_invalid_exception, ex_zx} & {4{op != OP_NONE}};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_stat_q <= 4'h0;
    else if (bus_wr_go && avs_address == `REG_IRQ_STATUS)
      irq_stat_q <= (irq_stat_q & ~avs_writedata[3:0]) | irq_ev; // set beats clear
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_mask_q <= 4'h0;
    else if (bus_wr_go && avs_address == `REG_IRQ_MASK && avs_byteenable[0])
      irq_mask_q <= avs_writedata[3:0];
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // bus slave: every access answers at the second edge after it starts
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !bus_ack_q;
  assign bus_wr_go = avs_write && bus_ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      bus_ack_q <= 1'b0;
    else
      bus_ack_q <= bus_req && !bus_ack_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack_q)
    begin
      case (avs_address)
        `REG_STATUS_CTRL: avs_readdata <= sc_q;
        `REG_COND_ONE: avs_readdata <= {28'h000_0000, cond_field_one};
        `REG_IRQ_STATUS: avs_readdata <= {28'h000_0000, irq_stat_q};
        `REG_IRQ_MASK: avs_readdata <= {28'h000_0000, irq_mask_q};
        `REG_DEP_TRACK: avs_readdata <= {26'h000_0000, hist_arith_q[0], hist_tgt_q[0]};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // fp_recip_round_unit

// File: test/fp_regfile_model.sv
// register file model on the far side of the slice
// assumes: the bench preloads sources by hierarchical write to regs
`timescale 1ns/100ps
module fp_regfile_model (
  input wire logic sys_clk, // core clock
  input wire fp_slice_pkg::wb_s wb, // write port of the slice
  input wire logic [4:0] rd_idx, // register being read
  output logic [63:0] rd_data // its contents
);
  import fp_slice_pkg::*;
  logic [63:0] regs [32];
  // read is combinational so the operand meets the offer cycle
  assign rd_data = regs[rd_idx];
  always @(posedge sys_clk)
  begin
    if (wb.valid === 1'b1)
      regs[wb.target] <= wb.data;
  end
endmodule // fp_regfile_model

// File: test/fp_recip_round_unit_chk.sv
// protocol checker for the reciprocal / round-to-single slice
// assumes: bound to fp_recip_round_unit, one clock domain
`timescale 1ns/100ps
module fp_recip_round_unit_chk (
  input wire logic sys_clk, // core clock
  input wire logic rst, // async reset
  input wire logic issue_valid, // offer
  input wire logic [31:0] issue_instr, // word
  input wire logic issue_claim, // ours
  input wire logic [4:0] source_fp_reg, // read index
  input wire fp_slice_pkg::wb_s wb, // write port
  input wire logic [31:0] fp_status_control, // status
  input wire logic [3:0] cond_field_one, // field one
  input wire logic cond_field_one_we, // field one strobe
  input wire logic avs_write, // bus write
  input wire logic avs_read, // bus read
  input wire logic avs_waitrequest // bus stall
);
  import fp_slice_pkg::*;
  logic dec_ok;
  logic rec_req;
  logic [4:0] tgt;
  logic [4:0] cls;
  assign dec_ok = (issue_instr[31:26] == 6'h3b && issue_instr[5:1] == 5'h18) ||
    (issue_instr[31:26] == 6'h3f && issue_instr[10:1] == 10'h00c);
  assign rec_req = issue_claim && issue_instr[0];
  assign tgt = issue_instr[25:21];
  assign cls = fp_status_control[16:12];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  claim_decode_a: assert property (issue_claim == (issue_valid && dec_ok))
    else $error("claim disagrees with decode");
  src_index_a: assert property (issue_valid |-> source_fp_reg == issue_instr[15:11])
    else $error("wrong source index");
  wb_cause_a: assert property (wb.valid |-> $past(issue_claim) && wb.target == $past(tgt))
    else $error("write without claim or wrong target");
  rec_one_a: assert property (rec_req |=> cond_field_one_we)
    else $error("record flag ignored");
  rec_zero_a: assert property (cond_field_one_we |-> $past(rec_req))
    else $error("field one written without record flag");
  cr_copy_a: assert property (cond_field_one_we |-> cond_field_one == fp_status_control[31:28])
    else $error("field one not the finished summary");
  stat_quiet_a: assert property (!$past(issue_claim) && !$past(avs_write) |-> $stable(fp_status_control))
    else $error("status moved with no cause");
  cls_kept_a: assert property ($past(issue_claim) && !wb.valid && !$past(avs_write) |-> $stable(cls))
    else $error("class changed on suppressed result");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus stall longer than one cycle");
  rec_c: cover property (rec_req ##1 cond_field_one_we);
  supp_c: cover property (issue_claim ##1 !wb.valid);
  bus_c: cover property (avs_read ##1 !avs_waitrequest);
endmodule // fp_recip_round_unit_chk

bind fp_recip_round_unit fp_recip_round_unit_chk i_fp_recip_round_unit_chk (
  .sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .issue_instr(issue_instr),
  .issue_claim(issue_claim), .source_fp_reg(source_fp_reg), .wb(wb),
  .fp_status_control(fp_status_control), .cond_field_one(cond_field_one),
  .cond_field_one_we(cond_field_one_we), .avs_write(avs_write), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest)
);

// File: test/tb_fp_recip_estimate_round_single.sv
// self-checking bench for the reciprocal / round-to-single slice
// assumes: checker bound from its own file, register file model beside
`timescale 1ns/100ps
module tb_fp_recip_estimate_round_single;
  import fp_slice_pkg::*;
  logic sys_clk;
  logic rst;
  logic issue_valid;
  logic [31:0] issue_instr;
  logic [63:0] src_data;
  logic [4:0] src_idx;
  logic fp_op_valid;
  logic [4:0] fp_op_target;
  logic fp_op_arith;
  wb_s wb;
  logic [31:0] st;
  logic [3:0] cr1;
  logic cr1_we;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic wbv;
  logic crw;
  logic [63:0] wbd;
  logic [31:0] rd;
  int num_errors;
  int num_checks;
  int cyc = 0;
  fp_recip_round_unit i_fp_recip_round_unit (
    .sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_src_data(src_data), .issue_claim(), .source_fp_reg(src_idx),
    .fp_op_valid(fp_op_valid), .fp_op_target(fp_op_target), .fp_op_arith(fp_op_arith),
    .wb(wb), .fp_status_control(st), .cond_field_one(cr1), .cond_field_one_we(cr1_we),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq)
  );
  fp_regfile_model i_fp_regfile_model (
    .sys_clk(sys_clk), .wb(wb), .rd_idx(src_idx), .rd_data(src_data)
  );
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one access; #1 lets a write land before the caller looks
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask
  // target and source always differ so the model's late write never hits the preload
  task automatic op(input logic [31:0] ins, input logic [63:0] v);
    i_fp_regfile_model.regs[ins[15:11]] = v;
    @(posedge sys_clk);
    issue_valid <= 1'b1;
    issue_instr <= ins;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    #1;
    wbv = wb.valid;
    wbd = wb.data;
    crw = cr1_we;
  endtask
  task automatic other(input logic [4:0] t, input logic ar);
    @(posedge sys_clk);
    fp_op_valid <= 1'b1;
    fp_op_target <= t;
    fp_op_arith <= ar;
    @(posedge sys_clk);
    fp_op_valid <= 1'b0;
  endtask
  function automatic logic [31:0] f_rcp(input logic rc);
    return {6'd59, 5'd1, 5'd0, 5'd2, 5'd0, 5'd24, rc};
  endfunction
  function automatic logic [31:0] f_rnd(input logic [4:0] s, input logic rc);
    return {6'd63, 5'd4, 5'd0, s, 10'd12, rc};
  endfunction
  task automatic t_recip();
    logic [63:0] iv [4] = '{64'h4000_0000_0000_0000, 64'h7ff0_0000_0000_0000,
      64'hfff0_0000_0000_0000, 64'h7ff8_0000_0000_0000};
    logic [63:0] ov [4] = '{64'h3fe0_0000_0000_0000, 64'h0000_0000_0000_0000,
      64'h8000_0000_0000_0000, 64'h7ff8_0000_0000_0000};
    logic [4:0] cv [4] = '{5'h04, 5'h02, 5'h12, 5'h11};
    real e;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 5'h00, 32'h0000_0000);
      op(f_rcp(1'b0), iv[i]);
      chk("rcp result", ov[i], wbd);
      chk("rcp class", cv[i], st[16:12]);
      chk("rcp summary", 1'b0, st[31]);
      chk("rcp strobe", 1'b0, crw);
    end
    op(f_rcp(1'b0), 64'h4008_0000_0000_0000);
    e = $bitstoreal(wbd) * 3.0 - 1.0;
    chk("rcp estimate", 1'b1, e < 1.0 / 256 && e > -1.0 / 256);
  endtask
  task automatic t_zero();
    bus(1'b1, 5'h00, 32'h0000_0000);
    op(f_rcp(1'b0), 64'h0000_0000_0000_0000);
    chk("zd result", 64'h7ff0_0000_0000_0000, wbd);
    chk("zd flags", 2'b11, {st[31], st[26]});
    bus(1'b1, 5'h00, 32'h0000_0010);
    op(f_rcp(1'b0), 64'h8000_0000_0000_0000);
    chk("zd write", 1'b0, wbv);
    chk("zd class", 5'h00, st[16:12]);
    chk("zd flag", 1'b1, st[26]);
  endtask
  task automatic t_snan();
    bus(1'b1, 5'h00, 32'h0000_0000);
    op(f_rcp(1'b1), 64'h7ff0_0000_0000_0001);
    chk("snan result", 64'h7ff8_0000_0000_0000, wbd);
    chk("snan class", 5'h11, st[16:12]);
    chk("snan flags", 2'b11, {st[29], st[24]});
    chk("cr1 strobe", 1'b1, crw);
    chk("cr1", 4'b1010, cr1);
    bus(1'b1, 5'h00, 32'h0000_0080);
    op(f_rcp(1'b1), 64'h7ff0_0000_0000_0001);
    chk("snan write", 1'b0, wbv);
    chk("cr1", 4'b1110, cr1);
    bus(1'b1, 5'h00, 32'h0000_0080);
    op(f_rnd(5'd2, 1'b0), 64'h7ff0_0000_0000_0001);
    chk("rnd snan write", 1'b0, wbv);
    chk("rnd snan class", 5'h00, st[16:12]);
  endtask
  task automatic t_round();
    logic [63:0] ev [4] = '{64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000,
      64'h3ff0_0000_2000_0000, 64'h3ff0_0000_0000_0000};
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, 5'h00, 32'(m));
      op(f_rnd(5'd2, m[0]), 64'h3ff0_0000_0040_0000);
      chk("rnd result", ev[m], wbd);
      chk("rnd inexact", 2'b11, {st[25], st[17]});
      chk("rnd class", 5'h04, st[16:12]);
      chk("rnd strobe", m[0], crw);
    end
  endtask
  task automatic t_defect();
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, 5'h00, 32'h0000_0000);
      other(5'd3, 1'b1);
      op(f_rnd(5'd3, 1'b0), {s[0], 63'h47ef_ffff_f800_0000});
      chk("defect result", {s[0], 63'h47f0_0000_0000_0000}, wbd);
      chk("defect ovf", 1'b0, st[28]);
    end
    bus(1'b0, 5'h08, 32'h0000_0000);
    chk("irq defect bit", 1'b1, rd[3]);
    bus(1'b1, 5'h0c, 32'h0000_000f);
    chk("irq raised", 1'b1, irq);
    bus(1'b1, 5'h0c, 32'h0000_0000);
    chk("irq masked", 1'b0, irq);
    bus(1'b1, 5'h0c, 32'h0000_000f);
    bus(1'b1, 5'h08, 32'h0000_000f);
    chk("irq cleared", 1'b0, irq);
    bus(1'b0, 5'h08, 32'h0000_0000);
    chk("irq status", 4'h0, rd[3:0]);
  endtask
  task automatic t_nodep();
    bus(1'b1, 5'h00, 32'h0000_0000);
    other(5'd3, 1'b1);
    other(5'd5, 1'b0);
    other(5'd6, 1'b0);
    op(f_rnd(5'd3, 1'b1), 64'h47ef_ffff_f800_0000);
    chk("ovf result", 64'h7ff0_0000_0000_0000, wbd);
    chk("ovf flag", 1'b1, st[28]);
    chk("cr1", 4'b1001, cr1);
  endtask
  task automatic t_decode();
    op({6'd59, 5'd1, 5'd0, 5'd2, 5'd0, 5'd25, 1'b0}, 64'h4000_0000_0000_0000);
    chk("foreign recip", 1'b0, wbv);
    op({6'd63, 5'd4, 5'd0, 5'd2, 10'd13, 1'b0}, 64'h4000_0000_0000_0000);
    chk("foreign round", 1'b0, wbv);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // no single test runs past a few hundred cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 4000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    issue_valid = 1'b0;
    issue_instr = 32'h0000_0000;
    fp_op_valid = 1'b0;
    fp_op_target = 5'd0;
    fp_op_arith = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk("status reset", 32'h0000_0000, rd);
    t_recip();
    t_zero();
    t_snan();
    t_round();
    t_defect();
    t_nodep();
    t_decode();
    wrap_up();
  end
endmodule // tb_fp_recip_estimate_round_single
